// ---- rtl/conv_defines.svh ----
// offsets, field positions, reset values and timing counts of the converter output port
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH

// sample word and pipeline
`define WORD_W           10
`define CONV_LATENCY     5
`define BUF_DEPTH        2

// system clock and channel indicator lag
`define SYS_CLK_NS       50
`define IND_LAG_NS       6
`define IND_LAG_CYC      ((`IND_LAG_NS / `SYS_CLK_NS) < 1 ? 1 : (`IND_LAG_NS / `SYS_CLK_NS))

// register byte offsets
`define ADR_W            8
`define CTRL_OFF         8'h00
`define STATUS_OFF       8'h04
`define CAPTURE_OFF      8'h08

// control fields
`define CTRL_TWOS_BIT    0
`define CTRL_SLEEP_BIT   1
`define CTRL_SHUT_BIT    2
`define CTRL_OE_N_BIT    3
`define CTRL_CAP_BIT     4
`define CTRL_RESET       5'h08

// status fields
`define STAT_IND_BIT     0
`define STAT_SLEEP_BIT   1
`define STAT_SHUT_BIT    2
`define STAT_OVR_BIT     3
`define STAT_CAPV_BIT    4

// capture fields
`define CAP_CHAN_BIT     10
`define CAP_VALID_BIT    31

`endif

// ---- rtl/conv_pkg.sv ----
// types shared by the converter output port and its capture buffer
`include "conv_defines.svh"
package conv_pkg;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_SHUTDOWN
  } power_mode_t;

  typedef struct packed {
    logic                   chan_first;
    logic [`WORD_W-1:0]     word;
  } capture_t;

endpackage : conv_pkg

// ---- rtl/sample_buf_if.sv ----
// valid/ready carrier between the output port and its capture buffer
`timescale 1ns/1ps
interface sample_buf_if import conv_pkg::*;;
  logic     in_valid;
  logic     in_ready;
  capture_t in_data;
  logic     out_valid;
  logic     out_ready;
  capture_t out_data;

  modport store (
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data
  );

  modport user (
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data
  );
endinterface : sample_buf_if

// ---- rtl/sample_buffer.sv ----
// small flip-flop fifo holding presented words for software readout
`timescale 1ns/1ps
`include "conv_defines.svh"
module sample_buffer import conv_pkg::*; #(
  parameter int DEPTH = `BUF_DEPTH
) (
  // clock and reset
  input wire logic     sys_clk,
  input wire logic     rst,
  // both sides of the buffer
  sample_buf_if.store  port
);
  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  capture_t          mem [DEPTH];
  logic [PW-1:0]     wr_ptr;
  logic [PW-1:0]     rd_ptr;
  logic [CW-1:0]     count;

  wire push = port.in_valid & port.in_ready;
  wire pop  = port.out_valid & port.out_ready;

  assign port.in_ready  = (count != FULL);
  assign port.out_valid = (count != '0);
  assign port.out_data  = mem[rd_ptr];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push & ~pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop & ~push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_mem
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          mem[i] <= '0;
        end else if (push && wr_ptr == PW'(i)) begin
          mem[i] <= port.in_data;
        end
      end
    end
  endgenerate
endmodule : sample_buffer

// ---- rtl/dual_adc_muxed_output_port.sv ----
// dual-channel converter output port: pipeline, shared bus, indicator, wishbone control
// How it works
// - with the format bit set words leave in two's complement, otherwise offset binary.
// - in sleep both channels stop sampling while the reference bias stays on.
// - with the full shutdown request set both channels and the reference bias are powered down.
// - while the active-low output enable is high the data pins are released.
// - the channel indicator is 1 while a first-channel word is on the bus, 0 for second.
// - the indicator follows the conversion clock level, lagging each edge slightly.
// - the bus is ten three-state bits, bit 0 the lsb and bit 9 the msb of the word.
// - both channels sample on a rising edge; first appears 5 rises later, second 5.5.
// - shutdown with output enable active holds the data bus and the indicator at their last values.
`timescale 1ns/1ps
`include "conv_defines.svh"
module dual_adc_muxed_output_port import conv_pkg::*; #(
  parameter int LATENCY = `CONV_LATENCY,
  parameter int DEPTH   = `BUF_DEPTH
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [`ADR_W-1:0]    adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // conversion clock pin and raw converter results
  input  wire logic                 conv_clk_pin,
  input  wire logic [`WORD_W-1:0]   first_channel_raw,
  input  wire logic [`WORD_W-1:0]   second_channel_raw,
  // shared sample bus and indicator pins
  output logic      [`WORD_W-1:0]   sample_bus_o,
  output logic                      sample_bus_oe,
  output logic                      channel_is_first,
  // power steering of the analog side
  output logic                      convert_enable,
  output logic                      ref_bias_on
);
  // control register
  logic [4:0]            ctrl;
  wire  format_twos      = ctrl[`CTRL_TWOS_BIT];
  wire  sleep_req        = ctrl[`CTRL_SLEEP_BIT];
  wire  full_shutdown_request = ctrl[`CTRL_SHUT_BIT];
  wire  output_enable_n  = ctrl[`CTRL_OE_N_BIT];
  wire  capture_en       = ctrl[`CTRL_CAP_BIT];

  // conversion clock synchroniser, level counted once stages 2 and 3 agree
  logic [2:0]            clk_sync;
  logic                  conv_lvl;
  wire  settled          = (clk_sync[1] == clk_sync[2]);
  wire  conv_rise        = settled & clk_sync[2] & ~conv_lvl;
  wire  conv_fall        = settled & ~clk_sync[2] & conv_lvl;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_sync <= '0;
      conv_lvl <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], conv_clk_pin};
      if (settled) begin
        conv_lvl <= clk_sync[2];
      end
    end
  end

  // power mode
  power_mode_t           mode;
  power_mode_t           next_mode;

  always_comb begin
    next_mode = MODE_RUN;
    if (full_shutdown_request) begin
      next_mode = MODE_SHUTDOWN;
    end else if (sleep_req) begin
      next_mode = MODE_SLEEP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  logic running;
  logic frozen;
  always_comb begin
    case (mode)
      MODE_RUN: begin
        running = 1'b1;
        frozen  = 1'b0;
      end
      MODE_SLEEP: begin
        running = 1'b0;
        frozen  = 1'b0;
      end
      MODE_SHUTDOWN: begin
        running = 1'b0;
        frozen  = 1'b1;
      end
      default: begin
        running = 1'b0;
        frozen  = 1'b1;
      end
    endcase
  end

  assign convert_enable = running;
  assign ref_bias_on    = ~frozen;

  // sample pipeline, one stage per conversion clock rise
  logic [`WORD_W-1:0]    pipe_first  [LATENCY];
  logic [`WORD_W-1:0]    pipe_second [LATENCY];
  wire  advance          = conv_rise & running;

  genvar i;
  // the head stage has no predecessor, so it gets a branch of its own
  generate
    for (i = 0; i < LATENCY; i++) begin : g_pipe
      if (i == 0) begin : g_head
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            pipe_first[i]  <= '0;
            pipe_second[i] <= '0;
          end else if (advance) begin
            pipe_first[i]  <= first_channel_raw;
            pipe_second[i] <= second_channel_raw;
          end
        end
      end else begin : g_tail
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            pipe_first[i]  <= '0;
            pipe_second[i] <= '0;
          end else if (advance) begin
            pipe_first[i]  <= pipe_first[i-1];
            pipe_second[i] <= pipe_second[i-1];
          end
        end
      end
    end
  endgenerate

  // core words arrive offset binary; two's complement just flips the msb
  function automatic logic [`WORD_W-1:0] coded(input logic [`WORD_W-1:0] w,
                                               input logic twos);
    coded = twos ? {~w[`WORD_W-1], w[`WORD_W-2:0]} : w;
  endfunction : coded

  // presentation: first word on the rise, second word held for the fall
  logic [`WORD_W-1:0]    word_out;
  logic [`WORD_W-1:0]    second_hold;
  logic                  ind;
  logic                  presented;
  wire  present_first    = conv_rise & ~frozen;
  wire  present_second   = conv_fall & ~frozen;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      presented <= 1'b0;
    end else begin
      presented <= present_first | present_second;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_out <= '0;
    end else if (present_first) begin
      word_out <= coded(pipe_first[LATENCY-1], format_twos);
    end else if (present_second) begin
      word_out <= coded(second_hold, format_twos);
    end
  end

  // the second word waits half a period, so it is parked at the rise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      second_hold <= '0;
    end else if (present_first) begin
      second_hold <= pipe_second[LATENCY-1];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ind <= 1'b0;
    end else if (present_first) begin
      ind <= 1'b1;
    end else if (present_second) begin
      ind <= 1'b0;
    end
  end

  // frozen edges update nothing, so shutdown keeps the last word and level
  assign sample_bus_o     = word_out;
  assign sample_bus_oe    = ~output_enable_n;
  assign channel_is_first = ind;

  // capture of presented words for software; a full buffer skips and flags
  sample_buf_if          bi ();
  logic                  overrun;

  assign bi.in_valid   = presented & capture_en;
  assign bi.in_data    = '{chan_first: ind, word: word_out};
  wire  skipped        = bi.in_valid & ~bi.in_ready;

  sample_buffer #(
    .DEPTH (DEPTH)
  ) u_buffer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (bi.store)
  );

  // wishbone decode; the two low address bits never take part
  function automatic logic reg_hit(input logic [`ADR_W-1:0] adr,
                                   input logic [`ADR_W-1:0] off);
    reg_hit = (adr[`ADR_W-1:2] == off[`ADR_W-1:2]);
  endfunction : reg_hit

  wire  req        = cyc_i & stb_i & ~ack_o;
  wire  hit_ctrl   = reg_hit(adr_i, `CTRL_OFF);
  wire  hit_status = reg_hit(adr_i, `STATUS_OFF);
  wire  hit_cap    = reg_hit(adr_i, `CAPTURE_OFF);
  wire  wr_low     = req & we_i & sel_i[0];
  wire  clear_ovr  = wr_low & hit_status & dat_i[`STAT_OVR_BIT];
  assign bi.out_ready = req & ~we_i & hit_cap;

  logic [31:0] status_word;
  logic [31:0] capture_word;
  logic [31:0] read_word;

  always_comb begin
    status_word = '0;
    status_word[`STAT_IND_BIT]   = ind;
    status_word[`STAT_SLEEP_BIT] = (mode == MODE_SLEEP);
    status_word[`STAT_SHUT_BIT]  = frozen;
    status_word[`STAT_OVR_BIT]   = overrun;
    status_word[`STAT_CAPV_BIT]  = bi.out_valid;
    capture_word = '0;
    capture_word[`WORD_W-1:0]    = bi.out_data.word;
    capture_word[`CAP_CHAN_BIT]  = bi.out_data.chan_first;
    capture_word[`CAP_VALID_BIT] = bi.out_valid;
    if (hit_ctrl) begin
      read_word = {27'h0, ctrl};
    end else if (hit_status) begin
      read_word = status_word;
    end else if (hit_cap) begin
      read_word = capture_word;
    end else begin
      read_word = '0;
    end
  end

  // one-cycle answer: ack and data registered on the edge the request is seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // read data stands until the next read, writes leave it alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dat_o <= '0;
    end else if (req & ~we_i) begin
      dat_o <= read_word;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_low & hit_ctrl) begin
      ctrl <= dat_i[4:0];
    end
  end

  // a skipped word in the clearing cycle still leaves the flag set
  logic next_overrun;
  always_comb begin
    next_overrun = overrun;
    if (clear_ovr) begin
      next_overrun = 1'b0;
    end
    if (skipped) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
    end else begin
      overrun <= next_overrun;
    end
  end
endmodule : dual_adc_muxed_output_port

// ---- sim/adc_port_monitor.sv ----
// assertions on the converter output port pins and register bus
`timescale 1ns/1ps
`include "conv_defines.svh"
module adc_port_monitor (
  // clock, reset and register bus
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [`ADR_W-1:0] adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // converter pins
  input wire logic              conv_clk_pin,
  input wire logic [9:0]        sample_bus_o,
  input wire logic              sample_bus_oe,
  input wire logic              channel_is_first,
  input wire logic              convert_enable,
  input wire logic              ref_bias_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire take    = cyc_i && stb_i && !ack_o;
  wire ctrl_wr = take && we_i && sel_i[0] && adr_i[7:2] == 6'h00;
  chk_ack_answer: assert property (take |=> ack_o)
    else $error("no ack");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  chk_ack_stray: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("stray ack");
  chk_unmapped_zero: assert property (take && !we_i && adr_i[7:2] > 6'h02 |=> dat_o == 0)
    else $error("unmapped read not zero");
  chk_oe_follow: assert property (ctrl_wr |-> ##3
    sample_bus_oe == !$past(dat_i[3], 3))
    else $error("enable wrong");
  chk_run_mode: assert property (ctrl_wr |-> ##3
    convert_enable == !(|$past(dat_i[2:1], 3)))
    else $error("convert enable wrong");
  chk_bias_mode: assert property (ctrl_wr |-> ##3
    ref_bias_on == !$past(dat_i[2], 3))
    else $error("bias wrong");
  chk_ind_rise: assert property ($rose(conv_clk_pin) |-> ##[3:5]
    (channel_is_first || !ref_bias_on))
    else $error("indicator late high");
  chk_ind_fall: assert property ($fell(conv_clk_pin) |-> ##[3:5]
    (!channel_is_first || !ref_bias_on))
    else $error("indicator late low");
  chk_word_moves: assert property ($changed(sample_bus_o) |->
    $changed(channel_is_first))
    else $error("word moved alone");
  chk_hold_frozen: assert property (!ref_bias_on && !$past(ref_bias_on) |->
    $stable(sample_bus_o))
    else $error("word moved in shutdown");
  cover property (ctrl_wr);
  cover property ($rose(channel_is_first));
  cover property (take && !we_i && adr_i[7:2] == 6'h02);
endmodule : adc_port_monitor

bind dual_adc_muxed_output_port adc_port_monitor u_adc_port_monitor (.sys_clk, .rst, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .conv_clk_pin, .sample_bus_o,
  .sample_bus_oe, .channel_is_first, .convert_enable, .ref_bias_on);

// ---- sim/sample_receiver.sv ----
// receiving logic that splits bus words into the two channel streams
`timescale 1ns/1ps
module sample_receiver (
  // clock and pins
  input  wire logic       sys_clk,
  input  wire logic [9:0] bus,
  input  wire logic       bus_oe,
  input  wire logic       ind,
  // demultiplexed streams
  output logic      [9:0] first_word,
  output logic      [9:0] second_word
);
  logic ind_seen = 1'b0;
  // a released bus carries nothing, so it is ignored
  always @(posedge sys_clk) begin
    ind_seen <= ind;
    if (bus_oe && ind != ind_seen) begin
      if (ind) first_word <= bus;
      else second_word <= bus;
    end
  end
endmodule : sample_receiver

// ---- sim/testbench.sv ----
// self-checking bench of the converter output port
`timescale 1ns/1ps
`include "conv_defines.svh"
module testbench;
  logic        sys_clk = 1'b0, rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, q, q2;
  logic        ack_o, conv_clk_pin = 1'b0, sample_bus_oe, channel_is_first, ind_b;
  logic        convert_enable, ref_bias_on, run_conv = 1'b0, chk_on = 1'b0, twos = 1'b0;
  logic [9:0]  first_channel_raw = 10'h0, second_channel_raw = 10'h0;
  logic [9:0]  sample_bus_o, rx_first, rx_second, bus_b;
  int          errors = 0, total_checks = 0, cnt = 0, rnum = 0;

  dual_adc_muxed_output_port u_dual_adc_muxed_output_port (.sys_clk, .rst, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .conv_clk_pin, .first_channel_raw,
    .second_channel_raw, .sample_bus_o, .sample_bus_oe, .channel_is_first, .convert_enable,
    .ref_bias_on);
  sample_receiver u_sample_receiver (.sys_clk, .bus(sample_bus_o), .bus_oe(sample_bus_oe),
    .ind(channel_is_first), .first_word(rx_first), .second_word(rx_second));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [9:0] fw(input int n);
    return 10'(n * 37 + 5);
  endfunction : fw

  function automatic logic [9:0] fmt(input logic [9:0] w);
    return twos ? {~w[9], w[8:0]} : w;
  endfunction : fmt

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 100) check("ack wait", 0, 1);
  endtask : wb

  // word checks pause while a mode change settles
  task automatic set_ctrl(input logic [7:0] v);
    chk_on <= 1'b0;
    wb(1, `CTRL_OFF, {24'h0, v});
    twos <= v[0];
    repeat (30) @(posedge sys_clk);
    chk_on <= v[2:1] == 2'b00;
  endtask : set_ctrl

  // conversion clock of 12 cycles, a new sample value per rise
  always @(posedge sys_clk) begin
    if (run_conv) begin
      cnt <= cnt == 11 ? 0 : cnt + 1;
      conv_clk_pin <= cnt == 11 || cnt < 5;
      if (cnt == 11) begin
        rnum <= rnum + 1;
        first_channel_raw  <= fw(rnum + 1);
        second_channel_raw <= ~fw(rnum + 1);
      end
      if (chk_on && rnum > 5 && cnt == 5) begin
        check("first word", sample_bus_o, fmt(fw(rnum - 5)));
        check("indicator high", channel_is_first, 1);
      end
      if (chk_on && rnum > 5 && cnt == 11) begin
        check("second word", sample_bus_o, fmt(~fw(rnum - 5)));
        check("indicator low", channel_is_first, 0);
        check("receiver first", rx_first, fmt(fw(rnum - 5)));
        check("receiver second", rx_second, fmt(~fw(rnum - 5)));
      end
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // about thirty-five times the expected run
  initial begin
    #1000000;
    errors++;
    end_sim;
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    run_conv <= 1'b1;
    wb(0, `CTRL_OFF, 0);
    check("ctrl reset", q, 32'h08);
    check("oe at reset", sample_bus_oe, 0);
    wb(0, 8'h40, 0);
    check("unmapped read", q, 0);
    set_ctrl(8'h00);
    check("oe on", sample_bus_oe, 1);
    check("run mode", {ref_bias_on, convert_enable}, 2'b11);
    repeat (150) @(posedge sys_clk);
    set_ctrl(8'h01);
    repeat (100) @(posedge sys_clk);
    set_ctrl(8'h10);
    set_ctrl(8'h00);
    wb(0, `STATUS_OFF, 0);
    check("overrun", q[`STAT_OVR_BIT], 1);
    wb(0, `CAPTURE_OFF, 0);
    q2 = q;
    wb(0, `CAPTURE_OFF, 0);
    check("capture pair", {q2[31], q[31], q2[10] ^ q[10]}, 3'b111);
    wb(0, `CAPTURE_OFF, 0);
    check("capture empty", q[31], 0);
    wb(1, `STATUS_OFF, 32'h08);
    wb(0, `STATUS_OFF, 0);
    check("overrun cleared", q[`STAT_OVR_BIT], 0);
    set_ctrl(8'h02);
    check("sleep", {ref_bias_on, convert_enable}, 2'b10);
    wb(0, `STATUS_OFF, 0);
    check("status sleep", q[2:1], 2'b01);
    set_ctrl(8'h04);
    check("shutdown", {ref_bias_on, convert_enable}, 2'b00);
    bus_b = sample_bus_o;
    ind_b = channel_is_first;
    repeat (40) @(posedge sys_clk);
    check("frozen", {ind_b, bus_b}, {channel_is_first, sample_bus_o});
    wb(0, `STATUS_OFF, 0);
    check("status shutdown", q[2:1], 2'b10);
    set_ctrl(8'h0c);
    check("oe off", sample_bus_oe, 0);
    end_sim;
  end
endmodule : testbench
